// [verilog/sfm_regs_pkg.sv]
// Constants for the switch forwarding mode register bank
package sfm_regs_pkg;
	localparam logic [7:0] ACK_LAT_OFFSET = 8'h70;
	localparam logic [7:0] FWD_MODE_OFFSET = 8'h74;
	localparam int ACK_LAT_LSB = 16;
	localparam int ACK_LAT_W = 14;
	localparam int ACK_LAT_EN_BIT = 30;
	localparam int VGA_EN_BIT = 31;
	localparam logic [13:0] ACK_LAT_RST = 14'h0000;
	localparam logic ACK_LAT_EN_RST = 1'b0;
	localparam logic VGA_EN_RST = 1'b1;
	localparam int SF_BIT = 0;
	localparam int CT_LSB = 1;
	localparam int ARB_BIT = 3;
	localparam int CREDIT_BIT = 4;
	localparam int ORD_PORT_BIT = 5;
	localparam int ORD_TAG_BIT = 6;
	localparam int NP_SF_BIT = 7;
	localparam int PM_LSB = 8;
	localparam int RX_POL_BIT = 14;
	localparam int CMP_PAR_BIT = 15;
	localparam int DRV_35_LSB = 16;
	localparam int DRV_60_LSB = 21;
	localparam int DRV_HALF_LSB = 26;
	localparam logic [1:0] CT_RST = 2'h1;
	localparam logic [5:0] PM_RST = 6'h01;
	localparam logic [4:0] DRV_35_RST = 5'h13;
	localparam logic [4:0] DRV_60_RST = 5'h13;
	localparam logic [4:0] DRV_HALF_RST = 5'h02;
	localparam logic [7:0] BUILTIN_ACK_LAT = 8'hff;
	typedef enum logic [1:0] {
		SFM_PORT_UP,
		SFM_PORT_DOWN
	} sfm_port_t;
endpackage

// [verilog/sfm_regs.sv]
// Switch forwarding mode configuration registers for one port
// What this block does
// - A 14-bit read-write acknowledge latency value sits in bits 29:16 of offset 0x70, reset zero.
// - Bit 30 of offset 0x70 makes the user latency value replace the built-in one, reset zero.
// - Bit 31 of offset 0x70 is a read-only VGA range decode enable that resets to one.
// - Bit 0 of the upstream 0x74 register picks store-and-forward when set, cut-through when clear.
// - The cut-through threshold in bits 2:1 applies only from a slower port to a faster one.
// - Threshold code 0 starts at the midpoint, codes 1 to 3 start that many cycles earlier, reset 1.
// - With bit 3 set the arbiter stays on the granted port while it requests, credit or not.
// - With bit 3 clear the arbiter moves to a requesting port whose packet has enough credit.
// - Bit 4 set releases all credit types per update; clear releases one type per update.
// - Bit 5 set enforces ordering among packets bound for different egress ports.
// - Bit 6 set enforces ordering between completions with different tags.
// - Read-only bit 7 selects store-and-forward for non-posted packets, default zero.
// - Every field default can be replaced before use by the management bus or EEPROM autoload.
// - Downstream 0x74 holds only the power management parameter 13:8 and read-only bit 14.
`timescale 1ns/100ps
module sfm_regs #(
	parameter bit UPSTREAM = 1'b1
) (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_cfg_wr,
	input wire logic i_cfg_rd,
	input wire logic [7:0] i_cfg_addr,
	input wire logic [31:0] i_cfg_wdata,
	input wire logic [3:0] i_cfg_be,
	output logic [31:0] o_cfg_rdata,
	output logic o_cfg_hit,
	input wire logic i_preload_wr,
	input wire logic [7:0] i_preload_addr,
	input wire logic [31:0] i_preload_data,
	input wire logic i_slow_to_fast,
	input wire logic [7:0] i_half_len,
	output logic [7:0] o_fwd_start,
	output logic [7:0] o_ack_latency,
	output logic o_vga_decode_en,
	output logic o_store_forward,
	output logic o_np_store_forward,
	output logic o_credit_all_types,
	output logic o_order_cross_port,
	output logic o_order_cpl_tag,
	output logic [5:0] o_pm_ctrl,
	output logic o_rx_pol_inv_dis,
	input wire logic [2:0] i_arb_req,
	input wire logic [2:0] i_arb_credit_ok,
	output logic [2:0] o_arb_grant
);
	typedef struct packed {
		logic [13:0] ack_lat;
		logic ack_lat_en;
		logic vga_en;
		logic sf;
		logic [1:0] ct;
		logic arb_stay;
		logic credit_all;
		logic ord_port;
		logic ord_tag;
		logic np_sf;
		logic [5:0] pm;
		logic rx_pol;
		logic cmp_par;
		logic [4:0] drv35;
		logic [4:0] drv60;
		logic [4:0] drvhalf;
		logic [31:0] rdata;
		logic hit;
		logic [7:0] start;
		logic [1:0] grant;
		logic granted;
	} sfm_state_t;

	sfm_state_t st_reg;
	sfm_state_t st_next;
	logic [31:0] cur74;
	logic [31:0] cur70;
	logic [31:0] mask;
	logic [31:0] v;
	logic [1:0] idx;
	logic found;
	logic [1:0] p;

	always_comb begin
		p = 2'h0;
		cur70 = '0;
		cur70[sfm_regs_pkg::ACK_LAT_LSB +: sfm_regs_pkg::ACK_LAT_W] = st_reg.ack_lat;
		cur70[sfm_regs_pkg::ACK_LAT_EN_BIT] = st_reg.ack_lat_en;
		cur70[sfm_regs_pkg::VGA_EN_BIT] = st_reg.vga_en;
		cur74 = '0;
		cur74[sfm_regs_pkg::PM_LSB +: 6] = st_reg.pm;
		cur74[sfm_regs_pkg::RX_POL_BIT] = st_reg.rx_pol;
		if (UPSTREAM) begin
			cur74[sfm_regs_pkg::SF_BIT] = st_reg.sf;
			cur74[sfm_regs_pkg::CT_LSB +: 2] = st_reg.ct;
			cur74[sfm_regs_pkg::ARB_BIT] = st_reg.arb_stay;
			cur74[sfm_regs_pkg::CREDIT_BIT] = st_reg.credit_all;
			cur74[sfm_regs_pkg::ORD_PORT_BIT] = st_reg.ord_port;
			cur74[sfm_regs_pkg::ORD_TAG_BIT] = st_reg.ord_tag;
			cur74[sfm_regs_pkg::NP_SF_BIT] = st_reg.np_sf;
			cur74[sfm_regs_pkg::CMP_PAR_BIT] = st_reg.cmp_par;
			cur74[sfm_regs_pkg::DRV_35_LSB +: 5] = st_reg.drv35;
			cur74[sfm_regs_pkg::DRV_60_LSB +: 5] = st_reg.drv60;
			cur74[sfm_regs_pkg::DRV_HALF_LSB +: 5] = st_reg.drvhalf;
		end
		mask = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}}, {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};
		st_next = st_reg;
		st_next.hit = 1'b0;
		// Preload path may rewrite read-only fields too
		if (i_preload_wr) begin
			v = i_preload_data;
			if (i_preload_addr == sfm_regs_pkg::ACK_LAT_OFFSET) begin
				st_next.ack_lat = v[sfm_regs_pkg::ACK_LAT_LSB +: sfm_regs_pkg::ACK_LAT_W];
				st_next.ack_lat_en = v[sfm_regs_pkg::ACK_LAT_EN_BIT];
				st_next.vga_en = v[sfm_regs_pkg::VGA_EN_BIT];
			end else if (i_preload_addr == sfm_regs_pkg::FWD_MODE_OFFSET) begin
				st_next.pm = v[sfm_regs_pkg::PM_LSB +: 6];
				st_next.rx_pol = v[sfm_regs_pkg::RX_POL_BIT];
				if (UPSTREAM) begin
					st_next.sf = v[sfm_regs_pkg::SF_BIT];
					st_next.ct = v[sfm_regs_pkg::CT_LSB +: 2];
					st_next.arb_stay = v[sfm_regs_pkg::ARB_BIT];
					st_next.credit_all = v[sfm_regs_pkg::CREDIT_BIT];
					st_next.ord_port = v[sfm_regs_pkg::ORD_PORT_BIT];
					st_next.ord_tag = v[sfm_regs_pkg::ORD_TAG_BIT];
					st_next.np_sf = v[sfm_regs_pkg::NP_SF_BIT];
					st_next.cmp_par = v[sfm_regs_pkg::CMP_PAR_BIT];
					st_next.drv35 = v[sfm_regs_pkg::DRV_35_LSB +: 5];
					st_next.drv60 = v[sfm_regs_pkg::DRV_60_LSB +: 5];
					st_next.drvhalf = v[sfm_regs_pkg::DRV_HALF_LSB +: 5];
				end
			end
		end else if (i_cfg_wr) begin
			if (i_cfg_addr == sfm_regs_pkg::ACK_LAT_OFFSET) begin
				v = (cur70 & ~mask) | (i_cfg_wdata & mask);
				st_next.ack_lat = v[sfm_regs_pkg::ACK_LAT_LSB +: sfm_regs_pkg::ACK_LAT_W];
				st_next.ack_lat_en = v[sfm_regs_pkg::ACK_LAT_EN_BIT];
			end else if (i_cfg_addr == sfm_regs_pkg::FWD_MODE_OFFSET) begin
				v = (cur74 & ~mask) | (i_cfg_wdata & mask);
				st_next.pm = v[sfm_regs_pkg::PM_LSB +: 6];
				if (UPSTREAM) begin
					st_next.sf = v[sfm_regs_pkg::SF_BIT];
					st_next.ct = v[sfm_regs_pkg::CT_LSB +: 2];
					st_next.arb_stay = v[sfm_regs_pkg::ARB_BIT];
					st_next.credit_all = v[sfm_regs_pkg::CREDIT_BIT];
					st_next.ord_port = v[sfm_regs_pkg::ORD_PORT_BIT];
					st_next.ord_tag = v[sfm_regs_pkg::ORD_TAG_BIT];
				end
			end else begin
				v = '0;
			end
		end else begin
			v = '0;
		end
		// Read data registered, one cycle after the strobe
		if (i_cfg_rd) begin
			st_next.hit = (i_cfg_addr == sfm_regs_pkg::ACK_LAT_OFFSET) ||
				(i_cfg_addr == sfm_regs_pkg::FWD_MODE_OFFSET);
			if (i_cfg_addr == sfm_regs_pkg::ACK_LAT_OFFSET) begin
				st_next.rdata = cur70;
			end else if (i_cfg_addr == sfm_regs_pkg::FWD_MODE_OFFSET) begin
				st_next.rdata = cur74;
			end else begin
				st_next.rdata = '0;
			end
		end
		// Threshold only matters for slow to fast forwarding
		if (!UPSTREAM || st_reg.sf) begin
			st_next.start = '0;
		end else if (i_slow_to_fast) begin
			st_next.start = (i_half_len > {6'h00, st_reg.ct}) ?
				i_half_len - {6'h00, st_reg.ct} : 8'h00;
		end else begin
			st_next.start = 8'h00;
		end
		// Round-robin egress arbiter over three ports
		found = 1'b0;
		idx = st_reg.grant;
		if (st_reg.granted && st_reg.arb_stay && i_arb_req[st_reg.grant]) begin
			found = 1'b1;
		end else begin
			for (int k = 1; k <= 3; k++) begin
				p = 2'((32'(st_reg.grant) + 32'(k)) % 3);
				if (!found && i_arb_req[p] && i_arb_credit_ok[p]) begin
					found = 1'b1;
					idx = p;
				end
			end
		end
		st_next.granted = found;
		st_next.grant = idx;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			st_reg <= '0;
			st_reg.ack_lat <= sfm_regs_pkg::ACK_LAT_RST;
			st_reg.ack_lat_en <= sfm_regs_pkg::ACK_LAT_EN_RST;
			st_reg.vga_en <= sfm_regs_pkg::VGA_EN_RST;
			st_reg.ct <= sfm_regs_pkg::CT_RST;
			st_reg.pm <= sfm_regs_pkg::PM_RST;
			st_reg.drv35 <= sfm_regs_pkg::DRV_35_RST;
			st_reg.drv60 <= sfm_regs_pkg::DRV_60_RST;
			st_reg.drvhalf <= sfm_regs_pkg::DRV_HALF_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_cfg_rdata = st_reg.rdata;
	assign o_cfg_hit = st_reg.hit;
	assign o_fwd_start = st_reg.start;
	// Low bits of the user value feed the latency counter
	assign o_ack_latency = st_reg.ack_lat_en ? st_reg.ack_lat[7:0] :
		sfm_regs_pkg::BUILTIN_ACK_LAT;
	assign o_vga_decode_en = st_reg.vga_en;
	assign o_store_forward = UPSTREAM && st_reg.sf;
	assign o_np_store_forward = UPSTREAM && st_reg.np_sf;
	assign o_credit_all_types = UPSTREAM && st_reg.credit_all;
	assign o_order_cross_port = UPSTREAM && st_reg.ord_port;
	assign o_order_cpl_tag = UPSTREAM && st_reg.ord_tag;
	assign o_pm_ctrl = st_reg.pm;
	assign o_rx_pol_inv_dis = st_reg.rx_pol;
	assign o_arb_grant = st_reg.granted ? (3'b001 << st_reg.grant) : 3'b000;
endmodule // sfm_regs

// [verification/sfm_regs_checker.sv]
// Assertion checker for the forwarding mode register bank
`timescale 1ns/100ps
module sfm_regs_checker (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_cfg_wr,
	input wire logic i_cfg_rd,
	input wire logic i_preload_wr,
	input wire logic [7:0] i_cfg_addr,
	input wire logic [31:0] o_cfg_rdata,
	input wire logic o_cfg_hit,
	input wire logic [7:0] o_ack_latency,
	input wire logic o_vga_decode_en,
	input wire logic o_store_forward,
	input wire logic [2:0] i_arb_req,
	input wire logic [2:0] o_arb_grant
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);
	// Quiet read, so no write races the readback
	sequence s_qrd(logic [7:0] a);
		i_cfg_rd && !i_cfg_wr && !i_preload_wr && i_cfg_addr == a;
	endsequence
	a_hit_mapped: assert property (i_cfg_rd && (i_cfg_addr == 8'h70 || i_cfg_addr == 8'h74)
		|=> o_cfg_hit) else $error("mapped read gave no hit");
	a_unmapped_zero: assert property (i_cfg_rd && i_cfg_addr != 8'h70 && i_cfg_addr != 8'h74
		|=> !o_cfg_hit && o_cfg_rdata == 32'h0000_0000) else $error("unmapped read not empty");
	a_hit_pulse: assert property (o_cfg_hit |-> $past(i_cfg_rd)) else $error("hit without read");
	a_ack_select: assert property (s_qrd(8'h70) |=> (o_cfg_rdata[30] ?
		o_ack_latency == o_cfg_rdata[23:16] : o_ack_latency == 8'hff)) else $error("ack latency");
	a_vga_match: assert property (s_qrd(8'h70) |=> o_vga_decode_en == o_cfg_rdata[31])
		else $error("vga enable differs");
	a_sf_match: assert property (s_qrd(8'h74) |=> o_store_forward == o_cfg_rdata[0])
		else $error("store forward differs");
	a_grant_onehot: assert property ($onehot0(o_arb_grant)) else $error("grant not one-hot");
	a_grant_req: assert property (o_arb_grant != 3'h0 |-> (o_arb_grant & $past(i_arb_req)) != 3'h0)
		else $error("grant to idle port");
	a_idle_none: assert property (i_arb_req == 3'h0 |=> o_arb_grant == 3'h0)
		else $error("grant with no request");
endmodule // sfm_regs_checker
bind sfm_regs sfm_regs_checker chk_u (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_cfg_wr(i_cfg_wr),
	.i_cfg_rd(i_cfg_rd), .i_preload_wr(i_preload_wr), .i_cfg_addr(i_cfg_addr),
	.o_cfg_rdata(o_cfg_rdata), .o_cfg_hit(o_cfg_hit), .o_ack_latency(o_ack_latency),
	.o_vga_decode_en(o_vga_decode_en), .o_store_forward(o_store_forward),
	.i_arb_req(i_arb_req), .o_arb_grant(o_arb_grant));

// [verification/sfm_regs_tb.sv]
// Self-checking bench for the forwarding mode register bank
`timescale 1ns/100ps
module sfm_regs_tb;
	logic clk = 0, srst = 1, wr = 0, rd = 0, pl = 0, s2f = 0, hit, vga, sf, npsf, cal, ocp, oct, rxp;
	logic [7:0] addr = 0, pla = 0, half = 8'h14, fst, ack;
	logic [31:0] wd = 0, pld = 0, rdata;
	logic [3:0] be = 0;
	logic [2:0] req = 0, cok = 0, gnt;
	logic [5:0] pm, pm_dn;
	logic [31:0] rdata_dn;
	logic [7:0] fst_dn;
	logic hit_dn, sf_dn, npsf_dn, cal_dn, ocp_dn, oct_dn, rxp_dn;
	int fails = 0, cmp_count = 0;
	always #5 clk = ~clk;
	sfm_regs #(.UPSTREAM(1'b1)) dut_u (.i_ref_clk(clk), .i_srst(srst), .i_cfg_wr(wr), .i_cfg_rd(rd),
		.i_cfg_addr(addr), .i_cfg_wdata(wd), .i_cfg_be(be), .o_cfg_rdata(rdata), .o_cfg_hit(hit),
		.i_preload_wr(pl), .i_preload_addr(pla), .i_preload_data(pld), .i_slow_to_fast(s2f),
		.i_half_len(half), .o_fwd_start(fst), .o_ack_latency(ack), .o_vga_decode_en(vga),
		.o_store_forward(sf), .o_np_store_forward(npsf), .o_credit_all_types(cal),
		.o_order_cross_port(ocp), .o_order_cpl_tag(oct), .o_pm_ctrl(pm), .o_rx_pol_inv_dis(rxp),
		.i_arb_req(req), .i_arb_credit_ok(cok), .o_arb_grant(gnt));
	// Downstream variant shares every input, so each write lands in both
	sfm_regs #(.UPSTREAM(1'b0)) dut_dn_u (.i_ref_clk(clk), .i_srst(srst), .i_cfg_wr(wr),
		.i_cfg_rd(rd), .i_cfg_addr(addr), .i_cfg_wdata(wd), .i_cfg_be(be),
		.o_cfg_rdata(rdata_dn), .o_cfg_hit(hit_dn), .i_preload_wr(pl), .i_preload_addr(pla),
		.i_preload_data(pld), .i_slow_to_fast(s2f), .i_half_len(half), .o_fwd_start(fst_dn),
		.o_ack_latency(), .o_vga_decode_en(), .o_store_forward(sf_dn),
		.o_np_store_forward(npsf_dn), .o_credit_all_types(cal_dn),
		.o_order_cross_port(ocp_dn), .o_order_cpl_tag(oct_dn), .o_pm_ctrl(pm_dn),
		.o_rx_pol_inv_dis(rxp_dn), .i_arb_req(req), .i_arb_credit_ok(cok), .o_arb_grant());
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wrt(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wd <= d;
		be <= b;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic h);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk("rdata", e, rdata);
		chk("hit", {31'h0, h}, {31'h0, hit});
	endtask
	task automatic t_ack();
		rdc(8'h70, 32'h8000_0000, 1'b1);
		rdc(8'h7c, 32'h0000_0000, 1'b0);
		chk("vga", 32'h1, {31'h0, vga});
		wrt(8'h70, 32'h7012_0000, 4'hf);
		rdc(8'h70, 32'hf012_0000, 1'b1);
		chk("ack", 32'h12, {24'h0, ack});
		// Top lane only: bit 30 drops, lane 2 keeps its value
		wrt(8'h70, 32'h0000_0000, 4'h8);
		rdc(8'h70, 32'h8012_0000, 1'b1);
		chk("ack", 32'hff, {24'h0, ack});
		$display("test ack done");
	endtask
	task automatic t_fwd();
		rdc(8'h74, 32'h0a73_0102, 1'b1);
		chk("rdata_dn", 32'h0000_0100, rdata_dn);
		wrt(8'h74, 32'hffff_ffff, 4'hf);
		rdc(8'h74, 32'h0a73_3f7f, 1'b1);
		chk("rdata_dn", 32'h0000_3f00, rdata_dn);
		chk("hit_dn", 32'h1, {31'h0, hit_dn});
		chk("flags_dn", 32'h0, {27'h0, sf_dn, cal_dn, ocp_dn, oct_dn, npsf_dn});
		chk("pm_dn", 32'h3f, {26'h0, pm_dn});
		chk("flags", 32'h1e, {27'h0, sf, cal, ocp, oct, npsf});
		chk("pm", 32'h3f, {26'h0, pm});
		@(posedge clk);
		s2f <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			wrt(8'h74, {29'h0, c[1:0], 1'b0}, 4'h1);
			repeat (2) @(negedge clk);
			chk("start", 32'h14 - c, {24'h0, fst});
			chk("start_dn", 32'h0, {24'h0, fst_dn});
		end
		wrt(8'h74, 32'h0000_0007, 4'h1);
		repeat (2) @(negedge clk);
		chk("start_sf", 32'h0, {24'h0, fst});
		wrt(8'h74, 32'h0000_0006, 4'h1);
		s2f <= 1'b0;
		repeat (2) @(negedge clk);
		chk("start_same", 32'h0, {24'h0, fst});
		$display("test fwd done");
	endtask
	task automatic t_preload();
		@(posedge clk);
		pl <= 1'b1;
		pla <= 8'h74;
		pld <= 32'h0000_4080;
		@(posedge clk);
		pl <= 1'b0;
		@(negedge clk);
		chk("np_sf", 32'h1, {31'h0, npsf});
		chk("rx_pol", 32'h1, {31'h0, rxp});
		chk("rx_pol_dn", 32'h1, {31'h0, rxp_dn});
		$display("test preload done");
	endtask
	task automatic t_arb();
		wrt(8'h74, 32'h0000_0000, 4'h1);
		req <= 3'b011;
		cok <= 3'b010;
		repeat (2) @(negedge clk);
		chk("grant", 32'h2, {29'h0, gnt});
		wrt(8'h74, 32'h0000_0008, 4'h1);
		cok <= 3'b001;
		repeat (3) @(negedge clk);
		chk("grant_hold", 32'h2, {29'h0, gnt});
		wrt(8'h74, 32'h0000_0000, 4'h1);
		repeat (2) @(negedge clk);
		chk("grant_move", 32'h1, {29'h0, gnt});
		$display("test arb done");
	endtask
	task automatic t_reset();
		@(posedge clk);
		srst <= 1'b1;
		req <= 3'h0;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		chk("ack_rst", 32'hff, {24'h0, ack});
		chk("grant_rst", 32'h0, {29'h0, gnt});
		// Preload cleared the drive fields, so this read proves reset restores them
		rdc(8'h74, 32'h0a73_0102, 1'b1);
		chk("rdata_dn", 32'h0000_0100, rdata_dn);
		rdc(8'h70, 32'h8000_0000, 1'b1);
		$display("test reset done");
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		t_ack();
		t_fwd();
		t_preload();
		t_arb();
		t_reset();
		conclude();
	end
	// Whole run needs about 60 cycles
	initial begin
		#20000;
		fails++;
		conclude();
	end
endmodule // sfm_regs_tb
